// >>> occ_codec.sv
// Output CAN message codec: packs the status payload, unpacks the control payload.
// Assumes an Avalon-MM master for configuration and a CAN controller on payload ports.
//
// The placing of the registers and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ns
module occ_codec
    import occ_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    // Avalon-MM slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // Values from control logic and drive circuits
    input  wire logic [15:0] target_1,
    input  wire logic [15:0] target_2,
    input  wire logic [15:0] meas_current_1,
    input  wire logic [15:0] meas_current_2,
    input  wire logic [15:0] applied_1,
    input  wire logic [15:0] applied_2,
    // Status payload toward the CAN controller
    output logic [63:0]      tx_payload_r,
    output logic [17:0]      tx_group_r,
    // Control payload from the CAN controller
    input  wire logic        rx_valid,
    input  wire logic [17:0] rx_group,
    input  wire logic [3:0]  rx_dlc,
    input  wire logic [63:0] rx_payload,
    // Decoded control values
    output logic [7:0]       cmd_1_r,
    output logic [7:0]       cmd_2_r,
    output logic [7:0]       loop_fb_1_r,
    output logic [7:0]       loop_fb_2_r,
    output logic             enable_1,
    output logic             enable_2,
    output logic             enable_err_1,
    output logic             enable_err_2,
    output logic             override_1,
    output logic             override_err_1,
    output logic             rx_update_r
);

    logic [31:0] config_r;
    logic        rd_pend_r;
    logic [31:0] rd_data;
    logic        rx_take;
    logic        wr_cfg;

    occ_type_t type_1;
    occ_type_t type_2;
    assign type_1 = occ_type_t'(config_r[OCC_CFG_TYPE1 +: 2]);
    assign type_2 = occ_type_t'(config_r[OCC_CFG_TYPE2 +: 2]);

    // Target field by type; one-byte kinds zero the upper byte
    function automatic logic [15:0] occ_enc_target(input occ_type_t t, input logic [15:0] v);
        logic [15:0] r;
        r = 16'h0000;
        unique case (t)
            OCC_TYPE_CURRENT: r = v;
            OCC_TYPE_VOLTAGE: r = v;
            OCC_TYPE_PWM:     r = {8'h00, (v[7:0] > OCC_PCT_FULL) ? OCC_PCT_FULL : v[7:0]};
            OCC_TYPE_DIGITAL: r = {8'h00, 7'h00, (v != 16'h0000)};
        endcase
        return r;
    endfunction : occ_enc_target

    // Feedback: measured current, else the value applied to the port
    function automatic logic [15:0] occ_enc_fbk(input occ_type_t t, input logic [15:0] cur,
                                                input logic [15:0] app);
        return (t == OCC_TYPE_CURRENT) ? cur : app;
    endfunction : occ_enc_fbk

    // Percent byte, clamped to full scale
    function automatic logic [7:0] occ_dec_pct(input logic [7:0] b);
        return (b > OCC_PCT_FULL) ? OCC_PCT_FULL : b;
    endfunction : occ_dec_pct

    logic [15:0] tgt1_enc;
    logic [15:0] tgt2_enc;
    logic [15:0] fbk1_enc;
    logic [15:0] fbk2_enc;
    assign tgt1_enc = occ_enc_target(type_1, target_1);
    assign tgt2_enc = occ_enc_target(type_2, target_2);
    assign fbk1_enc = occ_enc_fbk(type_1, meas_current_1, applied_1);
    assign fbk2_enc = occ_enc_fbk(type_2, meas_current_2, applied_2);

    // Status payload, refreshed every enabled cycle so a type change shows next cycle
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_payload_r <= 64'h0;
            tx_group_r   <= OCC_PG_STATUS;
        end
        else if (clk_en)
        begin
            // Bytes 1-2 target 1, 3-4 feedback 1, 5-6 target 2, 7-8 feedback 2
            tx_payload_r <= {fbk2_enc, tgt2_enc, fbk1_enc, tgt1_enc};
            tx_group_r   <= OCC_PG_STATUS;
        end
    end

    // Bus slave: writes complete at once, reads take one wait cycle
    assign wr_cfg = avs_write && (avs_address == OCC_A_CONFIG);
    assign avs_waitrequest = avs_read && !rd_pend_r;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            config_r <= OCC_CFG_RESET;
        end
        else if (clk_en && wr_cfg)
        begin
            for (int i = 0; i < 4; i++)
            begin
                if (avs_byteenable[i])
                begin
                    config_r[i*8 +: 8] <= avs_writedata[i*8 +: 8];
                end
            end
        end
    end

    always_comb
    begin
        rd_data = OCC_UNMAPPED;
        unique case (avs_address)
            OCC_A_CONFIG:  rd_data = {27'h0, config_r[4:0]};
            OCC_A_TARGET1: rd_data = {16'h0, tx_payload_r[15:0]};
            OCC_A_FBK1:    rd_data = {16'h0, tx_payload_r[31:16]};
            OCC_A_TARGET2: rd_data = {16'h0, tx_payload_r[47:32]};
            OCC_A_FBK2:    rd_data = {16'h0, tx_payload_r[63:48]};
            OCC_A_TXLO:    rd_data = tx_payload_r[31:0];
            OCC_A_TXHI:    rd_data = tx_payload_r[63:32];
            OCC_A_RXLO:    rd_data = {cmd_2_r, cmd_1_r, loop_fb_2_r, loop_fb_1_r};
            OCC_A_RXHI:    rd_data = {26'h0, enable_err_2, enable_err_1, override_err_1,
                                      override_1, enable_2, enable_1};
            OCC_A_STATE:   rd_data = {31'h0, rx_update_r};
            default:       rd_data = OCC_UNMAPPED;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_pend_r    <= 1'b0;
            avs_readdata <= 32'h0;
        end
        else if (clk_en)
        begin
            rd_pend_r <= avs_read && !rd_pend_r;
            if (avs_read && !rd_pend_r)
            begin
                avs_readdata <= rd_data;
            end
        end
    end

    // Only an enabled channel with the control group and full length is decoded;
    // no parameter numbers are looked for in the payload
    assign rx_take = rx_valid && config_r[OCC_CFG_RXEN]
                     && (rx_group == OCC_PG_CONTROL)
                     && (rx_dlc == OCC_CTRL_DLC);

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cmd_1_r     <= 8'h0;
            cmd_2_r     <= 8'h0;
            loop_fb_1_r <= 8'h0;
            loop_fb_2_r <= 8'h0;
            rx_update_r <= 1'b0;
        end
        else if (clk_en)
        begin
            rx_update_r <= rx_take;
            if (rx_take)
            begin
                cmd_1_r     <= occ_dec_pct(rx_payload[OCC_POS_CMD1*8 +: 8]);
                cmd_2_r     <= occ_dec_pct(rx_payload[OCC_POS_CMD2*8 +: 8]);
                loop_fb_1_r <= occ_dec_pct(rx_payload[OCC_POS_FB1*8 +: 8]);
                loop_fb_2_r <= occ_dec_pct(rx_payload[OCC_POS_FB2*8 +: 8]);
            end
        end
    end

    occ_field_dec u_en1 (
        .clock   (clock),
        .rst_n   (rst_n),
        .clk_en  (clk_en),
        .load    (rx_take),
        .code    (rx_payload[OCC_POS_EN1*8 +: 2]),
        .state_r (enable_1),
        .err_r   (enable_err_1)
    );

    occ_field_dec u_en2 (
        .clock   (clock),
        .rst_n   (rst_n),
        .clk_en  (clk_en),
        .load    (rx_take),
        .code    (rx_payload[OCC_POS_EN2*8 +: 2]),
        .state_r (enable_2),
        .err_r   (enable_err_2)
    );

    occ_field_dec u_ovr1 (
        .clock   (clock),
        .rst_n   (rst_n),
        .clk_en  (clk_en),
        .load    (rx_take),
        .code    (rx_payload[OCC_POS_OVR1*8 +: 2]),
        .state_r (override_1),
        .err_r   (override_err_1)
    );

    property p_rx_disabled;
        @(posedge clock) disable iff (!rst_n)
        (clk_en && rx_valid && !config_r[OCC_CFG_RXEN]) |=> !rx_update_r;
    endproperty
    a_rx_disabled: assert property (p_rx_disabled) else $error("decode while disabled");

    property p_tgt_current;
        @(posedge clock) disable iff (!rst_n)
        (rst_n && clk_en && type_1 == OCC_TYPE_CURRENT)
            |=> tx_payload_r[15:0] == $past(target_1);
    endproperty
    a_tgt_current: assert property (p_tgt_current) else $error("current target wrong");

    property p_tgt_digital;
        @(posedge clock) disable iff (!rst_n)
        (clk_en && type_2 == OCC_TYPE_DIGITAL) |=> tx_payload_r[47:33] == 15'h0;
    endproperty
    a_tgt_digital: assert property (p_tgt_digital) else $error("digital target over 01");

    property p_fbk_applied;
        @(posedge clock) disable iff (!rst_n)
        (clk_en && type_1 != OCC_TYPE_CURRENT) |=> tx_payload_r[31:16] == $past(applied_1);
    endproperty
    a_fbk_applied: assert property (p_fbk_applied) else $error("feedback not applied");

    property p_fbk_current;
        @(posedge clock) disable iff (!rst_n)
        (rst_n && clk_en && type_2 == OCC_TYPE_CURRENT)
            |=> tx_payload_r[63:48] == $past(meas_current_2);
    endproperty
    a_fbk_current: assert property (p_fbk_current) else $error("feedback not current");

    property p_cmd_scale;
        @(posedge clock) disable iff (!rst_n)
        (clk_en && rx_take) |=> cmd_1_r <= OCC_PCT_FULL && rx_update_r;
    endproperty
    a_cmd_scale: assert property (p_cmd_scale) else $error("command out of range");

    property p_en_err;
        @(posedge clock) disable iff (!rst_n)
        (clk_en && rx_take && rx_payload[OCC_POS_EN1*8 +: 2] == OCC_ST_ERR)
            |=> enable_err_1 && !enable_1;
    endproperty
    a_en_err: assert property (p_en_err) else $error("enable error not disabling");

    property p_ovr_hold;
        @(posedge clock) disable iff (!rst_n)
        (clk_en && rx_take && rx_payload[OCC_POS_OVR1*8 +: 2] == 2'h3)
            |=> override_1 == $past(override_1);
    endproperty
    a_ovr_hold: assert property (p_ovr_hold) else $error("ignored code changed state");

    property p_ovr_err;
        @(posedge clock) disable iff (!rst_n)
        (clk_en && rx_take && rx_payload[OCC_POS_OVR1*8 +: 2] == OCC_ST_ERR) |=> !override_1;
    endproperty
    a_ovr_err: assert property (p_ovr_err) else $error("override error not off");

    // Sampled reset in the antecedent keeps the release edge from starting a false attempt
    property p_tgt_voltage;
        @(posedge clock) disable iff (!rst_n)
        (rst_n && clk_en && type_2 == OCC_TYPE_VOLTAGE)
            |=> tx_payload_r[47:32] == $past(target_2);
    endproperty
    a_tgt_voltage: assert property (p_tgt_voltage) else $error("voltage target wrong");

    property p_tgt_pwm;
        @(posedge clock) disable iff (!rst_n)
        (rst_n && clk_en && type_1 == OCC_TYPE_PWM)
            |=> tx_payload_r[15:8] == 8'h00 && tx_payload_r[7:0] <= OCC_PCT_FULL;
    endproperty
    a_tgt_pwm: assert property (p_tgt_pwm) else $error("pwm target out of range");

    property p_tgt_digital_on;
        @(posedge clock) disable iff (!rst_n)
        (rst_n && clk_en && type_1 == OCC_TYPE_DIGITAL)
            |=> tx_payload_r[15:0] == {15'h0000, $past(target_1) != 16'h0000};
    endproperty
    a_tgt_digital_on: assert property (p_tgt_digital_on) else $error("digital state wrong");

    property p_fbk_current_1;
        @(posedge clock) disable iff (!rst_n)
        (rst_n && clk_en && type_1 == OCC_TYPE_CURRENT)
            |=> tx_payload_r[31:16] == $past(meas_current_1);
    endproperty
    a_fbk_current_1: assert property (p_fbk_current_1) else $error("feedback 1 not current");

    property p_fbk_applied_2;
        @(posedge clock) disable iff (!rst_n)
        (rst_n && clk_en && type_2 != OCC_TYPE_CURRENT)
            |=> tx_payload_r[63:48] == $past(applied_2);
    endproperty
    a_fbk_applied_2: assert property (p_fbk_applied_2) else $error("feedback 2 not applied");

    property p_en_on;
        @(posedge clock) disable iff (!rst_n)
        (clk_en && rx_take && rx_payload[OCC_POS_EN2*8 +: 2] == OCC_ST_ON)
            |=> enable_2 && !enable_err_2;
    endproperty
    a_en_on: assert property (p_en_on) else $error("enable on not decoded");

    property p_fb_decode;
        @(posedge clock) disable iff (!rst_n)
        (clk_en && rx_take && rx_payload[OCC_POS_FB1*8 +: 8] <= OCC_PCT_FULL)
            |=> loop_fb_1_r == $past(rx_payload[OCC_POS_FB1*8 +: 8]);
    endproperty
    a_fb_decode: assert property (p_fb_decode) else $error("loop feedback wrong");

    property p_group_filter;
        @(posedge clock) disable iff (!rst_n)
        (rst_n && clk_en && rx_valid && (rx_group != OCC_PG_CONTROL || rx_dlc != OCC_CTRL_DLC))
            |=> !rx_update_r;
    endproperty
    a_group_filter: assert property (p_group_filter) else $error("foreign frame decoded");

endmodule : occ_codec

// >>> occ_ecu_model.sv
// Far-side control unit: drives control frames at the codec's receive port.
// Assumes one frame per call, started just after a rising clock edge.
`timescale 1ns/1ns
module occ_ecu_model
    import occ_pkg::*;
(
    input  wire logic  clock,
    output logic       rx_valid,
    output logic [17:0] rx_group,
    output logic [3:0]  rx_dlc,
    output logic [63:0] rx_payload
);
    initial
    begin
        rx_valid   = 1'b0;
        rx_group   = 18'h0;
        rx_dlc     = 4'h0;
        rx_payload = 64'h0;
    end

    // One byte per field; unused bits and byte are sent as ones
    function automatic logic [63:0] frame(input logic [7:0] c1, input logic [7:0] c2,
        input logic [7:0] f1, input logic [7:0] f2, input logic [1:0] e1,
        input logic [1:0] e2, input logic [1:0] o1);
        frame = {8'hFF, 6'h3F, o1, 6'h3F, e2, 6'h3F, e1, f2, f1, c2, c1};
    endfunction : frame

    task automatic send(input logic [17:0] grp, input logic [3:0] dlc, input logic [63:0] pl);
        rx_valid   <= 1'b1;
        rx_group   <= grp;
        rx_dlc     <= dlc;
        rx_payload <= pl;
        @(posedge clock);
        // Lines no longer hold the frame once the strobe drops
        rx_valid   <= 1'b0;
        rx_group   <= ~grp;
        rx_dlc     <= ~dlc;
        rx_payload <= ~pl;
    endtask : send
endmodule : occ_ecu_model

// >>> occ_field_dec.sv
// Two-bit state field decoder with hold on ignored codes.
// Assumes its strobe comes from logic on the same clock.
`timescale 1ns/1ns
module occ_field_dec
    import occ_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       clk_en,
    input  wire logic       load,
    input  wire logic [1:0] code,
    output logic            state_r,
    output logic            err_r
);

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= 1'b0;
            err_r   <= 1'b0;
        end
        else if (clk_en && load)
        begin
            unique case (code)
                OCC_ST_OFF:
                begin
                    state_r <= 1'b0;
                    err_r   <= 1'b0;
                end
                OCC_ST_ON:
                begin
                    state_r <= 1'b1;
                    err_r   <= 1'b0;
                end
                OCC_ST_ERR:
                begin
                    // Error forces the state off
                    state_r <= 1'b0;
                    err_r   <= 1'b1;
                end
                default:
                begin
                    // Ignored code: previous state holds
                    state_r <= state_r;
                    err_r   <= err_r;
                end
            endcase
        end
    end

endmodule : occ_field_dec

// >>> occ_pkg.sv
// Package for the output CAN message codec: field layouts, codes, offsets.
// Assumes a host CPU on Avalon-MM and a CAN controller that moves raw 8-byte payloads.
package occ_pkg;

    // Output types
    typedef enum logic [1:0] {OCC_TYPE_CURRENT, OCC_TYPE_VOLTAGE, OCC_TYPE_PWM, OCC_TYPE_DIGITAL}
        occ_type_t;

    // Parameter groups and proprietary parameter numbers
    localparam logic [17:0] OCC_PG_STATUS      = 18'h0FF10;  // 65296
    localparam logic [17:0] OCC_PG_CONTROL     = 18'h0FF80;  // 65408
    localparam logic [19:0] OCC_PN_FEEDBACK_1  = 20'h7F100;
    localparam logic [19:0] OCC_PN_FEEDBACK_2  = 20'h7F101;
    localparam logic [0:0]  OCC_CTRL_DATA_PAGE = 1'h0;
    localparam logic [7:0]  OCC_CTRL_PDU_FMT   = 8'hFE;      // 254
    localparam logic [2:0]  OCC_CTRL_PRIORITY  = 3'h6;
    localparam logic [3:0]  OCC_CTRL_DLC       = 4'h8;
    localparam int          OCC_CTRL_REPEAT_MS = 100;

    // Control payload byte positions (start position 1 is byte 0)
    localparam int OCC_POS_CMD1  = 0;
    localparam int OCC_POS_CMD2  = 1;
    localparam int OCC_POS_FB1   = 2;
    localparam int OCC_POS_FB2   = 3;
    localparam int OCC_POS_EN1   = 4;
    localparam int OCC_POS_EN2   = 5;
    localparam int OCC_POS_OVR1  = 6;

    // Two-bit state codes
    localparam logic [1:0] OCC_ST_OFF = 2'h0;
    localparam logic [1:0] OCC_ST_ON  = 2'h1;
    localparam logic [1:0] OCC_ST_ERR = 2'h2;

    // Decoded command/feedback full scale: 250 counts = 100 percent
    localparam logic [7:0] OCC_PCT_FULL = 8'hFA;

    // Register word addresses (Avalon word index)
    localparam logic [3:0] OCC_A_CONFIG  = 4'h0;
    localparam logic [3:0] OCC_A_TARGET1 = 4'h1;
    localparam logic [3:0] OCC_A_TARGET2 = 4'h2;
    localparam logic [3:0] OCC_A_FBK1    = 4'h3;
    localparam logic [3:0] OCC_A_FBK2    = 4'h4;
    localparam logic [3:0] OCC_A_TXLO    = 4'h5;
    localparam logic [3:0] OCC_A_TXHI    = 4'h6;
    localparam logic [3:0] OCC_A_RXLO    = 4'h7;
    localparam logic [3:0] OCC_A_RXHI    = 4'h8;
    localparam logic [3:0] OCC_A_STATE   = 4'h9;

    // Config field positions
    localparam int OCC_CFG_TYPE1 = 0;
    localparam int OCC_CFG_TYPE2 = 2;
    localparam int OCC_CFG_RXEN  = 4;
    localparam logic [31:0] OCC_CFG_RESET = 32'h0000_0000;
    localparam logic [31:0] OCC_UNMAPPED  = 32'h0000_0000;

endpackage : occ_pkg

// >>> output_can_message_codec_test.sv
// Self-checking bench for the output CAN message codec.
// Assumes the codec answers reads after one wait cycle and writes at once.
`timescale 1ns/1ns
module output_can_message_codec_test
    import occ_pkg::*;
;
    logic        clock, rst_n, avs_read, avs_write, rx_valid, rx_update_r, clk_en;
    logic        enable_1, enable_2, enable_err_1, enable_err_2, override_1, override_err_1;
    logic [3:0]  avs_address, rx_dlc;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic        avs_waitrequest;
    logic [15:0] target_1, target_2, meas_1, meas_2, app_1, app_2, w, e1, e2;
    logic [63:0] tx_payload_r, rx_payload;
    logic [17:0] tx_group_r, rx_group;
    logic [7:0]  cmd_1_r, cmd_2_r, loop_fb_1_r, loop_fb_2_r;
    logic [1:0]  seq [6];
    logic        s1, x1, s2, x2, so, xo;
    int          miscompares, n_checks;

    occ_codec occ_codec_i (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .target_1(target_1), .target_2(target_2),
        .meas_current_1(meas_1), .meas_current_2(meas_2), .applied_1(app_1),
        .applied_2(app_2), .tx_payload_r(tx_payload_r), .tx_group_r(tx_group_r),
        .rx_valid(rx_valid), .rx_group(rx_group), .rx_dlc(rx_dlc), .rx_payload(rx_payload),
        .cmd_1_r(cmd_1_r), .cmd_2_r(cmd_2_r), .loop_fb_1_r(loop_fb_1_r),
        .loop_fb_2_r(loop_fb_2_r), .enable_1(enable_1), .enable_2(enable_2),
        .enable_err_1(enable_err_1), .enable_err_2(enable_err_2), .override_1(override_1),
        .override_err_1(override_err_1), .rx_update_r(rx_update_r));

    occ_ecu_model occ_ecu_model_i (.clock(clock), .rx_valid(rx_valid), .rx_group(rx_group),
        .rx_dlc(rx_dlc), .rx_payload(rx_payload));

    always #50 clock = ~clock;

    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim

    task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // Avalon access: request held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        @(posedge clock);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= we;
        avs_read      <= ~we;
        n = 0;
        @(posedge clock);
        while (avs_waitrequest !== 1'b0 && n < 20)
        begin
            n++;
            @(posedge clock);
        end
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        if (n >= 20)
        begin
            chk("waitrequest", 64'h0, 64'h1);
            end_sim();
        end
    endtask : bus

    // Frame on the link, then count update pulses over a fixed window
    task automatic rx(input logic [17:0] g, input logic [3:0] dl, input logic [63:0] pl,
        input logic exp);
        int seen;
        @(posedge clock);
        occ_ecu_model_i.send(g, dl, pl);
        seen = 0;
        repeat (4)
        begin
            @(posedge clock);
            if (rx_update_r === 1'b1)
                seen++;
        end
        chk("rx_update", {63'h0, exp}, 64'(seen));
    endtask : rx

    task automatic upd(input logic [1:0] c, inout logic s, inout logic x);
        if (c != 2'h3)
        begin
            s = (c == OCC_ST_ON);
            x = (c == OCC_ST_ERR);
        end
    endtask : upd

    initial
    begin
        clock = 1'b0;
        rst_n = 1'b0;
        clk_en = 1'b1;
        {avs_read, avs_write, avs_address, avs_writedata} = '0;
        target_1 = 16'h1234;
        target_2 = 16'h00C8;
        meas_1   = 16'h0ABC;
        meas_2   = 16'h0DEF;
        app_1    = 16'h0567;
        app_2    = 16'h0089;
        seq = '{2'h3, 2'h2, 2'h3, 2'h1, 2'h3, 2'h0};
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        chk("tx_group", 64'(OCC_PG_STATUS), 64'(tx_group_r));
        bus(1'b0, OCC_A_CONFIG, 32'h0, rd);
        chk("config", 64'(OCC_CFG_RESET), 64'(rd));
        bus(1'b1, 4'hF, 32'hFFFF_FFFF, rd);
        bus(1'b0, 4'hF, 32'h0, rd);
        chk("unmapped", 64'(OCC_UNMAPPED), 64'(rd));
        // Receive stays shut until enabled
        rx(OCC_PG_CONTROL, OCC_CTRL_DLC, occ_ecu_model_i.frame(8'h7D, 8'hFA, 8'h10, 8'hFF,
            2'h1, 2'h0, 2'h1), 1'b0);
        chk("cmd_1", 64'h0, 64'(cmd_1_r));
        bus(1'b1, OCC_A_CONFIG, 32'h10, rd);
        rx(OCC_PG_CONTROL, OCC_CTRL_DLC, occ_ecu_model_i.frame(8'h7D, 8'hFA, 8'h10, 8'hFF,
            2'h1, 2'h0, 2'h1), 1'b1);
        chk("cmd_1", 64'h7D, 64'(cmd_1_r));
        chk("cmd_2", 64'hFA, 64'(cmd_2_r));
        chk("loop_fb_1", 64'h10, 64'(loop_fb_1_r));
        chk("loop_fb_2", 64'(OCC_PCT_FULL), 64'(loop_fb_2_r));
        chk("states", 64'h5, 64'({enable_1, enable_2, override_1}));
        // Frames of another group or length leave everything alone
        rx(OCC_PG_STATUS, OCC_CTRL_DLC, 64'h0, 1'b0);
        rx(OCC_PG_CONTROL, 4'h7, 64'h0, 1'b0);
        chk("cmd_1", 64'h7D, 64'(cmd_1_r));
        {s1, x1, s2, x2, so, xo} = 6'b100010;
        foreach (seq[i])
        begin
            rx(OCC_PG_CONTROL, OCC_CTRL_DLC, occ_ecu_model_i.frame(8'h7D, 8'hFA, 8'h10,
                8'hFF, seq[i], seq[i], seq[i]), 1'b1);
            upd(seq[i], s1, x1);
            upd(seq[i], s2, x2);
            upd(seq[i], so, xo);
            chk("enable_1", 64'({s1, x1}), 64'({enable_1, enable_err_1}));
            chk("enable_2", 64'({s2, x2}), 64'({enable_2, enable_err_2}));
            chk("override_1", 64'({so, xo}), 64'({override_1, override_err_1}));
        end
        for (int t = 0; t < 4; t++)
        begin
            bus(1'b1, OCC_A_CONFIG, 32'h10 | 32'(t * 5), rd);
            repeat (3) @(posedge clock);
            w  = (t < 2) ? 16'hFFFF : 16'h00FF;
            e1 = (t == 2) ? 16'h0034 : (t == 3) ? 16'h0001 : target_1;
            e2 = (t == 2) ? 16'h00C8 : (t == 3) ? 16'h0001 : target_2;
            chk("tx_target_1", 64'(e1 & w), 64'(tx_payload_r[15:0] & w));
            chk("tx_fbk_1", 64'((t == 0) ? meas_1 : app_1), 64'(tx_payload_r[31:16]));
            chk("tx_target_2", 64'(e2 & w), 64'(tx_payload_r[47:32] & w));
            chk("tx_fbk_2", 64'((t == 0) ? meas_2 : app_2), 64'(tx_payload_r[63:48]));
            bus(1'b0, OCC_A_TXLO, 32'h0, rd);
            chk("tx_low_word", 64'({(t == 0) ? meas_1 : app_1, e1 & w}),
                64'(rd & {16'hFFFF, w}));
        end
        // Frozen clock enable: a good frame must leave every decoded value alone
        clk_en <= 1'b0;
        rx(OCC_PG_CONTROL, OCC_CTRL_DLC, occ_ecu_model_i.frame(8'h01, 8'h02, 8'h03, 8'h04,
            2'h0, 2'h1, 2'h0), 1'b0);
        chk("cmd_1_frozen", 64'h7D, 64'(cmd_1_r));
        chk("enable_2_frozen", 64'h0, 64'({enable_2, enable_err_2}));
        clk_en <= 1'b1;
        @(posedge clock);
        target_1 <= 16'h0000;
        repeat (3) @(posedge clock);
        chk("tx_digital_off", 64'h0, 64'(tx_payload_r[7:0]));
        end_sim();
    end
endmodule : output_can_message_codec_test
